// *** shared/acr_defines.svh ***
// Purpose: Constants for the auxiliary control register access block
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// System register encodings {op0,op1,crn,crm,op2}
`define ACR_ENC_AUX_ID      16'hC807
`define ACR_ENC_AUX_CTL_LL  16'hC081
`define ACR_ENC_AUX_CTL_HL  16'hE081
`define ACR_ENC_HYP_TRAP    16'hE08F
// Exception levels
`define ACR_EL0             2'h0
`define ACR_EL1             2'h1
`define ACR_EL2             2'h2
`define ACR_EL3             2'h3
// Trap syndrome class
`define ACR_EC_SYSREG       6'h18
// Nested virtualisation memory offset
`define ACR_NEST_MEM_OFS    12'h118
// Write-enable bit positions
`define ACR_BIT_PERF        12
`define ACR_BIT_SCHEME      11
`define ACR_BIT_TSID        10
`define ACR_BIT_PWR         7
`define ACR_BIT_ECTL        1
`define ACR_BIT_ACTL        0
// Writable mask of hypervisor-level control register
`define ACR_HL_WMASK        64'h0000_0000_0000_1C83
`define ACR_RESET_VAL       64'h0000_0000_0000_0000
// Register slots
`define ACR_SLOT_LL         2'h0
`define ACR_SLOT_HL         2'h1
`define ACR_SLOT_TRAP       2'h2
`define ACR_NSLOT           3
`endif

// *** shared/acr_pkg.sv ***
// Purpose: Types for the auxiliary control register access block
// Assumes: Used by scoped name only
// Notes:   No constants here; see acr_defines.svh
package acr_pkg;
    // Decode result
    typedef enum logic [2:0] {
        ACR_ACC_REG   = 3'h0,
        ACR_ACC_UNDEF = 3'h1,
        ACR_ACC_TRAP  = 3'h2,
        ACR_ACC_NEST_MEM = 3'h3,
        ACR_ACC_RAZ   = 3'h4,
        ACR_ACC_NONE  = 3'h5
    } acr_result_type;
    // Hypervisor configuration bits of interest
    typedef struct packed {
        logic trap_general_exceptions;
        logic trap_identification_group1;
        logic trap_auxiliary_control;
        logic nested_virt_enable;
        logic nested_virt_mode1;
        logic nested_virt_mode2;
        logic host_extension;
    } acr_hyp_cfg_type;
    // Access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] enc;
        logic [1:0]  el;
        logic [63:0] wdata;
    } acr_req_type;
    // Access answer
    typedef struct packed {
        logic           valid;
        acr_result_type result;
        logic [1:0]     target_el;
        logic [5:0]     ec;
        logic [11:0]    nest_mem_ofs;
        logic [63:0]    rdata;
    } acr_rsp_type;
endpackage

// *** core/acr_decode.sv ***
// Purpose: Combinational permission decode for one system register access
// Assumes: Inputs stable within the cycle
// Notes:   Pure logic, no state
`timescale 1ns/1ps
`include "acr_defines.svh"
module acr_decode (
    // Request
    input  wire logic                     valid_i,
    input  wire logic [15:0]              enc_i,
    input  wire logic [1:0]               el_i,
    // Controls
    input  wire acr_pkg::acr_hyp_cfg_type cfg_i,
    input  wire logic                     el2_impl_i,
    input  wire logic                     el2_enabled_i,
    input  wire logic                     fgt_en_i,
    input  wire logic                     fg_aux_id_trap_i,
    // Result
    output acr_pkg::acr_result_type       result_o,
    output logic [1:0]                    target_el_o,
    output logic [1:0]                    slot_o
);
    logic nested_trap; // Nested-virt trap applies
    // Per-register decision tree
    always_comb begin
        nested_trap = el2_enabled_i & cfg_i.nested_virt_enable;
        result_o    = acr_pkg::ACR_ACC_NONE;
        target_el_o = `ACR_EL2;
        slot_o      = `ACR_SLOT_LL;
        if (!valid_i) begin
            result_o = acr_pkg::ACR_ACC_NONE;
        end else if (enc_i == `ACR_ENC_AUX_ID) begin
            if (el_i == `ACR_EL0) begin
                result_o = acr_pkg::ACR_ACC_TRAP; // R2
                target_el_o = (el2_enabled_i & cfg_i.trap_general_exceptions) ?
                              `ACR_EL2 : `ACR_EL1; // R2
            end else if (el_i == `ACR_EL1 && el2_enabled_i
                         && cfg_i.trap_identification_group1) begin
                result_o = acr_pkg::ACR_ACC_TRAP; // R3
            end else if (el_i == `ACR_EL1 && el2_enabled_i && fgt_en_i
                         && fg_aux_id_trap_i) begin
                result_o = acr_pkg::ACR_ACC_TRAP; // R4
            end else begin
                result_o = acr_pkg::ACR_ACC_RAZ; // R1
            end
        end else if (enc_i == `ACR_ENC_AUX_CTL_LL) begin
            if (el_i == `ACR_EL0) begin
                result_o = acr_pkg::ACR_ACC_UNDEF; // R6
            end else if (el_i == `ACR_EL1 && el2_enabled_i
                         && cfg_i.trap_auxiliary_control) begin
                result_o = acr_pkg::ACR_ACC_TRAP; // R6
            end else if (el_i == `ACR_EL1 && el2_enabled_i && cfg_i.nested_virt_mode2
                         && cfg_i.nested_virt_enable) begin
                result_o = acr_pkg::ACR_ACC_NEST_MEM; // R7
            end else begin
                result_o = acr_pkg::ACR_ACC_REG; // R22
            end
        end else if (enc_i == `ACR_ENC_AUX_CTL_HL || enc_i == `ACR_ENC_HYP_TRAP) begin
            slot_o = (enc_i == `ACR_ENC_AUX_CTL_HL) ? `ACR_SLOT_HL : `ACR_SLOT_TRAP;
            if (el_i == `ACR_EL0) begin
                result_o = acr_pkg::ACR_ACC_UNDEF; // R8
            end else if (el_i == `ACR_EL1) begin
                result_o = nested_trap ? acr_pkg::ACR_ACC_TRAP
                                       : acr_pkg::ACR_ACC_UNDEF; // R8
            end else if (!el2_impl_i) begin
                result_o = acr_pkg::ACR_ACC_RAZ; // R16
            end else begin
                result_o = acr_pkg::ACR_ACC_REG; // R22
            end
        end
    end
endmodule // acr_decode

// *** core/acr_regfile.sv ***
// Purpose: Three 64-bit control registers with registered read data
// Assumes: One write per cycle
// Notes:   Masks applied by the caller
`timescale 1ns/1ps
`include "acr_defines.svh"
module acr_regfile (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Write port
    input  wire logic        we_i,
    input  wire logic [1:0]  wslot_i,
    input  wire logic [63:0] wdata_i,
    // Read port
    input  wire logic [1:0]  rslot_i,
    output logic [63:0]      rdata_o,
    // Direct view of the hypervisor-level slot
    output logic [63:0]      hl_o
);
    logic [63:0] mem_reg  [`ACR_NSLOT]; // Storage
    logic [63:0] mem_next [`ACR_NSLOT]; // Next storage
    logic [63:0] rd_reg;                // Registered read data
    logic [63:0] rd_next;               // Next read data
    // Next-state for each slot
    genvar g;
    generate
        for (g = 0; g < `ACR_NSLOT; g++) begin : g_slot
            always_comb begin
                mem_next[g] = mem_reg[g];
                if (we_i && wslot_i == 2'(g)) begin
                    mem_next[g] = wdata_i;
                end
            end
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    mem_reg[g] <= `ACR_RESET_VAL;
                end else begin
                    mem_reg[g] <= mem_next[g];
                end
            end
        end
    endgenerate
    // Read select
    always_comb begin
        rd_next = (rslot_i < 2'(`ACR_NSLOT)) ? mem_reg[rslot_i] : `ACR_RESET_VAL;
    end
    // Read register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rd_reg <= `ACR_RESET_VAL;
        end else begin
            rd_reg <= rd_next;
        end
    end
    assign rdata_o = rd_reg;
    assign hl_o    = mem_reg[`ACR_SLOT_HL];
endmodule // acr_regfile

// *** core/acr_top.sv ***
// Purpose: Access control for auxiliary identification and control registers
// Assumes: One request per cycle from the core; answer one cycle later
// Notes:   Register storage and read data reset to zero; reserved bits read zero
`timescale 1ns/1ps
`include "acr_defines.svh"

// Overview of operation
// [R1] Identification register reads as zero
// [R2] Lowest-level identification read traps, class 0x18
// [R3] Kernel read traps on identification-group trap
// [R4] Kernel read traps on fine-grained trap
// [R5] Lower control register reads zero, resets zero
// [R6] Lower control: undefined lowest, trap on control-trap
// [R7] Nested-virt pattern redirects to memory 0x118
// [R8] Hypervisor control: undefined or nested-virt trap
// [R9] Bit 12 gates cluster perf writes
// [R10] Bit 11 gates scheme-management writes
// [R11] Bit 10 gates thread scheme ID writes
// [R12] Bit 7 gates power control writes
// [R13] Bit 1 gates extended control writes
// [R14] Bit 0 gates auxiliary control writes
// [R15] Reserved bits zero, enables reset clear
// [R16] Without hypervisor, reserved-zero from monitor level
// [R17] Hypervisor registers inert when hypervisor disabled
// [R18] Lower control inert under host trap-all
// [R19] Hypervisor control applies to lowest under host
// [R20] Trap control register all zero, no traps
// [R21] No needless traps under host trap-all
// [R22] Hypervisor and monitor access registers directly
module acr_top (
    // Clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     rst_i,
    // Configuration from the core
    input  wire acr_pkg::acr_hyp_cfg_type cfg_i,
    input  wire logic                     el2_impl_i,
    input  wire logic                     el2_enabled_i,
    input  wire logic                     fgt_en_i,
    input  wire logic                     fg_aux_id_trap_i,
    // Register access request and answer
    input  wire acr_pkg::acr_req_type     req_i,
    output acr_pkg::acr_rsp_type          rsp_o,
    // Write gate query from kernel level, one bit per group
    input  wire logic [5:0]               grp_wr_req_i,
    input  wire logic [5:0]               grp_hyp_writable_i,
    output logic [5:0]                    grp_wr_allow_o,
    // Effective controls
    output logic [63:0]                   eff_ctl_lower_o,
    output logic [63:0]                   eff_ctl_hyp_o
);
    acr_pkg::acr_result_type res;       // Decode result
    logic [1:0]              tgt_el;    // Trap target
    logic [1:0]              slot;      // Register slot
    logic                    we;        // Register write strobe
    logic [63:0]             wdata;     // Masked write data
    logic [63:0]             rd;        // Registered read data
    logic [63:0]             hl_val;    // Hypervisor control value
    logic                    host_trap_all; // Hypervisor enabled with host extension and trap-general set
    logic [5:0]              en_bits;   // Write-enable bits
    // Answer pipeline
    logic                    v_reg, v_next;
    acr_pkg::acr_result_type r_reg, r_next;
    logic [1:0]              t_reg, t_next;
    logic                    zero_reg, zero_next;

    // Permission decode
    acr_decode acr_decode_inst (
        .valid_i          (req_i.valid),
        .enc_i            (req_i.enc),
        .el_i             (req_i.el),
        .cfg_i            (cfg_i),
        .el2_impl_i       (el2_impl_i),
        .el2_enabled_i    (el2_enabled_i),
        .fgt_en_i         (fgt_en_i),
        .fg_aux_id_trap_i (fg_aux_id_trap_i),
        .result_o         (res),
        .target_el_o      (tgt_el),
        .slot_o           (slot)
    );

    // Write data shaping; all lower and trap bits are reserved
    always_comb begin
        we    = req_i.valid && req_i.write && res == acr_pkg::ACR_ACC_REG
                && req_i.enc != `ACR_ENC_AUX_ID;
        wdata = `ACR_RESET_VAL; // R5 R20
        if (slot == `ACR_SLOT_HL) begin
            wdata = req_i.wdata & `ACR_HL_WMASK; // R15
        end
    end

    // Storage with registered read port
    acr_regfile acr_regfile_inst (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .we_i    (we),
        .wslot_i (slot),
        .wdata_i (wdata),
        .rslot_i (slot),
        .rdata_o (rd),
        .hl_o    (hl_val)
    );

    // Answer stage next values
    always_comb begin
        v_next    = req_i.valid;
        r_next    = res;
        t_next    = tgt_el;
        // Identification and RAZ results give zero data
        zero_next = (res != acr_pkg::ACR_ACC_REG) || req_i.write; // R1 R16
    end

    // Answer stage registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            v_reg    <= 1'b0;
            r_reg    <= acr_pkg::ACR_ACC_NONE;
            t_reg    <= `ACR_EL2;
            zero_reg <= 1'b1;
        end else begin
            v_reg    <= v_next;
            r_reg    <= r_next;
            t_reg    <= t_next;
            zero_reg <= zero_next;
        end
    end

    // Answer fields
    always_comb begin
        rsp_o.valid     = v_reg;
        rsp_o.result    = r_reg;
        rsp_o.target_el = t_reg;
        rsp_o.ec        = (r_reg == acr_pkg::ACR_ACC_TRAP) ? `ACR_EC_SYSREG : 6'h00;
        rsp_o.nest_mem_ofs = (r_reg == acr_pkg::ACR_ACC_NEST_MEM) ?
                             `ACR_NEST_MEM_OFS : 12'h000; // R7
        rsp_o.rdata     = zero_reg ? `ACR_RESET_VAL : rd;
    end

    // Write gates for kernel-level writes of cluster and core registers
    always_comb begin
        en_bits = {hl_val[`ACR_BIT_PERF], hl_val[`ACR_BIT_SCHEME], // R9 R10
                   hl_val[`ACR_BIT_TSID], hl_val[`ACR_BIT_PWR],    // R11 R12
                   hl_val[`ACR_BIT_ECTL], hl_val[`ACR_BIT_ACTL]};  // R13 R14
        if (!el2_enabled_i) begin
            // Hypervisor controls inert; gates open to the plain path
            grp_wr_allow_o = grp_wr_req_i; // R17
        end else begin
            grp_wr_allow_o = grp_wr_req_i & en_bits & grp_hyp_writable_i;
        end
    end

    // Effective control views; lower register yields to hypervisor one under host
    always_comb begin
        host_trap_all = el2_enabled_i && cfg_i.host_extension && cfg_i.trap_general_exceptions;
        if (host_trap_all) begin
            eff_ctl_lower_o = `ACR_RESET_VAL; // R18
            eff_ctl_hyp_o   = hl_val;         // R19
        end else begin
            eff_ctl_lower_o = `ACR_RESET_VAL;
            eff_ctl_hyp_o   = el2_enabled_i ? hl_val : `ACR_RESET_VAL; // R17
        end
    end
    // The trap control register holds only zeros, so it never raises a trap. R21
endmodule // acr_top

// *** testbench/acr_top_properties.sv ***
// Purpose: Timing and decode properties at the ports of acr_top
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound onto every acr_top instance
`timescale 1ns/1ps
module acr_props (
    // Clock and reset
    input wire logic                     mclk_i,
    input wire logic                     rst_i,
    // Controls
    input wire acr_pkg::acr_hyp_cfg_type cfg_i,
    input wire logic                     el2_impl_i,
    input wire logic                     el2_enabled_i,
    input wire logic                     fgt_en_i,
    input wire logic                     fg_aux_id_trap_i,
    // Access and answer
    input wire acr_pkg::acr_req_type     req_i,
    input wire acr_pkg::acr_rsp_type     rsp_o,
    // Write gates and effective controls
    input wire logic [5:0]               grp_wr_req_i,
    input wire logic [5:0]               grp_hyp_writable_i,
    input wire logic [5:0]               grp_wr_allow_o,
    input wire logic [63:0]              eff_ctl_lower_o,
    input wire logic [63:0]              eff_ctl_hyp_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Access taken at the lowest level, or at kernel level with hypervisor on
    wire k0 = req_i.valid && req_i.el == 2'h0;
    wire k1 = req_i.valid && req_i.el == 2'h1 && el2_enabled_i;
    answer_once_a: assert property (req_i.valid |=> rsp_o.valid) else $error("no answer");
    answer_quiet_a: assert property (!req_i.valid |=> !rsp_o.valid) else $error("stray");
    trap_class_a: assert property (rsp_o.valid && rsp_o.result == acr_pkg::ACR_ACC_TRAP
        |-> rsp_o.ec == 6'h18) else $error("bad class");
    id_lowest_a: assert property (k0 && req_i.enc == 16'hC807 && el2_enabled_i
        && cfg_i.trap_general_exceptions |=> rsp_o.result == acr_pkg::ACR_ACC_TRAP
        && rsp_o.target_el == 2'h2) else $error("id trap level");
    id_group_a: assert property (k1 && req_i.enc == 16'hC807
        && cfg_i.trap_identification_group1 |=> rsp_o.result == acr_pkg::ACR_ACC_TRAP
        && rsp_o.target_el == 2'h2) else $error("id group trap");
    lower_undef_a: assert property (k0 && req_i.enc == 16'hC081
        |=> rsp_o.result == acr_pkg::ACR_ACC_UNDEF) else $error("lower not undef");
    nested_mem_a: assert property (k1 && req_i.enc == 16'hC081
        && !cfg_i.trap_auxiliary_control && cfg_i.nested_virt_mode2 && cfg_i.nested_virt_enable
        |=> rsp_o.result == acr_pkg::ACR_ACC_NEST_MEM && rsp_o.nest_mem_ofs == 12'h118)
        else $error("no redirect");
    hyp_trap_a: assert property (k1 && (req_i.enc == 16'hE081 || req_i.enc == 16'hE08F)
        && cfg_i.nested_virt_enable |=> rsp_o.result == acr_pkg::ACR_ACC_TRAP
        && rsp_o.target_el == 2'h2) else $error("hyp no trap");
    reserved_zero_a: assert property ((eff_ctl_hyp_o & ~64'h1C83) == 64'h0
        && eff_ctl_lower_o == 64'h0) else $error("reserved bit set");
    hyp_inert_a: assert property (!el2_enabled_i |-> eff_ctl_hyp_o == 64'h0)
        else $error("hyp control live");
    perf_gate_a: assert property (el2_enabled_i && grp_wr_allow_o[5]
        |-> eff_ctl_hyp_o[12] && grp_hyp_writable_i[5]) else $error("perf gate");
endmodule // acr_props

bind acr_top acr_props acr_props_inst (
    .mclk_i, .rst_i, .cfg_i, .el2_impl_i, .el2_enabled_i, .fgt_en_i, .fg_aux_id_trap_i,
    .req_i, .rsp_o, .grp_wr_req_i, .grp_hyp_writable_i, .grp_wr_allow_o,
    .eff_ctl_lower_o, .eff_ctl_hyp_o
);

// *** testbench/acr_core_model.sv ***
// Purpose: Core model issuing one system register access at a time
// Assumes: Answer stands just after the taking edge
// Notes:   Released data shows its inverse, so stale words never match
`timescale 1ns/1ps
module acr_core_model (
    // Clock and answer
    input  wire logic                 mclk_i,
    input  wire acr_pkg::acr_rsp_type rsp_i,
    // Request to the block
    output acr_pkg::acr_req_type      req_o
);
    // Idle at time zero
    initial req_o = '0;
    // Raise after an edge, hold to the taking edge, take the answer, release
    task automatic issue(input logic w, input logic [15:0] e, input logic [1:0] l,
                         input logic [63:0] d, output acr_pkg::acr_rsp_type r);
        @(posedge mclk_i);
        #1 req_o = {1'b1, w, e, l, d};
        @(posedge mclk_i);
        #1 r = rsp_i;
        req_o = {1'b0, w, e, l, ~d};
    endtask
endmodule // acr_core_model

// *** testbench/acr_top_bench.sv ***
// Purpose: Self-checking bench for acr_top
// Assumes: Core model drives every access
// Notes:   Expectations come from the access tables only
`timescale 1ns/1ps
`include "acr_defines.svh"
module acr_top_bench;
    logic                     mclk_i = 1'b0; // 20 MHz clock
    logic                     rst_i  = 1'b1; // Held for 6 cycles
    acr_pkg::acr_hyp_cfg_type cfg    = '0;   // Hypervisor configuration
    logic                     impl = 1'b1, en = 1'b1, fgt = 1'b0, fgtrap = 1'b0;
    logic [5:0]               wr_req = '0, hyp_wr = '0, allow;
    acr_pkg::acr_req_type     req;
    acr_pkg::acr_rsp_type     rsp, r;
    logic [63:0]              eff_lo, eff_hy;
    int                       errors = 0, checks_done = 0, cycles = 0;
    int                       pos[6] = '{0, 1, 7, 10, 11, 12}; // Enable bit of each group

    acr_top acr_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_i(cfg), .el2_impl_i(impl),
        .el2_enabled_i(en), .fgt_en_i(fgt), .fg_aux_id_trap_i(fgtrap), .req_i(req),
        .rsp_o(rsp), .grp_wr_req_i(wr_req), .grp_hyp_writable_i(hyp_wr),
        .grp_wr_allow_o(allow), .eff_ctl_lower_o(eff_lo), .eff_ctl_hyp_o(eff_hy));
    acr_core_model acr_core_model_inst (.mclk_i(mclk_i), .rsp_i(rsp), .req_o(req));

    // Clock
    always #25 mclk_i = ~mclk_i;

    // Hang guard: far above the roughly 70 cycles the run needs
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check_val(input string n, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Outcome of the last access; level and class only matter on traps
    task automatic check_rsp(input string n, input acr_pkg::acr_result_type e,
                             input logic [1:0] t);
        check_val({n, " valid"}, 64'h1, 64'(r.valid));
        check_val({n, " result"}, 64'(e), 64'(r.result));
        if (e == acr_pkg::ACR_ACC_TRAP) begin
            check_val({n, " level"}, 64'(t), 64'(r.target_el));
            check_val({n, " class"}, 64'h18, 64'(r.ec));
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] e, input logic [1:0] l,
                       input logic [63:0] d);
        acr_core_model_inst.issue(w, e, l, d, r);
    endtask

    task automatic t_reset();
        acc(0, `ACR_ENC_AUX_CTL_HL, `ACR_EL2, '0);
        check_rsp("hyp read", acr_pkg::ACR_ACC_REG, 0);
        check_val("hyp reset", 64'h0, r.rdata);
        acc(0, `ACR_ENC_AUX_ID, `ACR_EL3, '0);
        check_rsp("id read", acr_pkg::ACR_ACC_RAZ, 0);
        check_val("id data", 64'h0, r.rdata);
        check_val("lower eff", 64'h0, eff_lo);
    endtask
    task automatic t_id();
        cfg.trap_general_exceptions = 1;
        acc(0, `ACR_ENC_AUX_ID, `ACR_EL0, '0);
        check_rsp("id el0 tge", acr_pkg::ACR_ACC_TRAP, 2);
        cfg = '0;
        acc(0, `ACR_ENC_AUX_ID, `ACR_EL0, '0);
        check_rsp("id el0", acr_pkg::ACR_ACC_TRAP, 1);
        cfg.trap_identification_group1 = 1;
        acc(0, `ACR_ENC_AUX_ID, `ACR_EL1, '0);
        check_rsp("id group", acr_pkg::ACR_ACC_TRAP, 2);
        cfg = '0;
        fgt = 1;
        fgtrap = 1;
        acc(0, `ACR_ENC_AUX_ID, `ACR_EL1, '0);
        check_rsp("id fine", acr_pkg::ACR_ACC_TRAP, 2);
        fgt = 0;
        acc(0, `ACR_ENC_AUX_ID, `ACR_EL1, '0);
        check_rsp("id plain", acr_pkg::ACR_ACC_RAZ, 0);
    endtask
    task automatic t_lower();
        acc(1, `ACR_ENC_AUX_CTL_LL, `ACR_EL0, '1);
        check_rsp("lower el0", acr_pkg::ACR_ACC_UNDEF, 0);
        cfg.trap_auxiliary_control = 1;
        cfg.nested_virt_mode2 = 1;
        cfg.nested_virt_enable = 1;
        acc(0, `ACR_ENC_AUX_CTL_LL, `ACR_EL1, '0);
        check_rsp("lower ctl trap", acr_pkg::ACR_ACC_TRAP, 2);
        cfg.trap_auxiliary_control = 0;
        for (int i = 0; i < 2; i++) begin
            cfg.nested_virt_mode1 = i[0];
            acc(1, `ACR_ENC_AUX_CTL_LL, `ACR_EL1, '1);
            check_rsp("lower nested", acr_pkg::ACR_ACC_NEST_MEM, 0);
            check_val("nested offset", 64'h118, 64'(r.nest_mem_ofs));
        end
        en = 0;
        acc(0, `ACR_ENC_AUX_CTL_LL, `ACR_EL1, '0);
        check_rsp("lower no hyp", acr_pkg::ACR_ACC_REG, 0);
        en = 1;
        cfg = '0;
    endtask
    task automatic t_hyp();
        for (int i = 0; i < 2; i++) begin
            cfg.nested_virt_enable = 0;
            acc(1, i ? `ACR_ENC_HYP_TRAP : `ACR_ENC_AUX_CTL_HL, `ACR_EL0, '1);
            check_rsp("hyp el0", acr_pkg::ACR_ACC_UNDEF, 0);
            acc(0, i ? `ACR_ENC_HYP_TRAP : `ACR_ENC_AUX_CTL_HL, `ACR_EL1, '0);
            check_rsp("hyp el1", acr_pkg::ACR_ACC_UNDEF, 0);
            cfg.nested_virt_enable = 1;
            acc(1, i ? `ACR_ENC_HYP_TRAP : `ACR_ENC_AUX_CTL_HL, `ACR_EL1, '1);
            check_rsp("hyp nested", acr_pkg::ACR_ACC_TRAP, 2);
        end
        cfg = '0;
    endtask
    task automatic t_gates();
        wr_req = 6'h3F;
        hyp_wr = 6'h3F;
        #1 check_val("gate reset", 64'h0, 64'(allow));
        acc(1, `ACR_ENC_AUX_CTL_HL, `ACR_EL2, '1);
        acc(0, `ACR_ENC_AUX_CTL_HL, `ACR_EL2, '0);
        check_val("hyp mask", 64'h1C83, r.rdata);
        hyp_wr = 6'h15;
        #1 check_val("gate hyp", 64'h15, 64'(allow));
        hyp_wr = 6'h3F;
        for (int i = 0; i < 6; i++) begin
            acc(1, `ACR_ENC_AUX_CTL_HL, `ACR_EL3, 64'h1 << pos[i]);
            check_val("gate one", 64'h1 << i, 64'(allow));
        end
        cfg.host_extension = 1;
        cfg.trap_general_exceptions = 1;
        #1 check_val("host hyp", 64'h1000, eff_hy);
        check_val("host lower", 64'h0, eff_lo);
        cfg = '0;
        en = 0;
        #1 check_val("hyp off", 64'h0, eff_hy);
        check_val("gate off", 64'h3F, 64'(allow));
    endtask
    task automatic t_nohyp();
        impl = 0;
        acc(1, `ACR_ENC_AUX_CTL_HL, `ACR_EL3, '1);
        check_rsp("no hyp", acr_pkg::ACR_ACC_RAZ, 0);
        check_val("no hyp data", 64'h0, r.rdata);
        impl = 1;
        en = 1;
        acc(0, `ACR_ENC_AUX_CTL_HL, `ACR_EL2, '0);
        check_val("hyp kept", 64'h1000, r.rdata);
        acc(1, `ACR_ENC_HYP_TRAP, `ACR_EL2, '1);
        acc(0, `ACR_ENC_HYP_TRAP, `ACR_EL2, '0);
        check_val("trap ctl", 64'h0, r.rdata);
        rst_i = 1;
        @(posedge mclk_i);
        #1 rst_i = 0;
        check_val("rerun eff", 64'h0, eff_hy);
        acc(0, `ACR_ENC_AUX_CTL_HL, `ACR_EL3, '0);
        check_val("rerun read", 64'h0, r.rdata);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk_i);
        #1 rst_i = 0;
        t_reset();
        t_id();
        t_lower();
        t_hyp();
        t_gates();
        t_nohyp();
        summarize();
    end
endmodule // acr_top_bench
